// ==== cmc_bus_node.sv ====
// Far-side CAN node and line transceiver seen by the mode control block
`timescale 1ns/1ps
module cmc_bus_node (
  input wire logic pclk,
  input wire logic bus_transmit_out,
  input wire logic node_dominant,
  output logic bus_receive_in
);
  logic pull_low_reg = 1'b0;
  // Other node pulls the bus low only when told; termination keeps it recessive
  always_ff @(posedge pclk) begin
    pull_low_reg <= node_dominant;
  end
  // Wired-AND of both transmitters, recessive high when idle
  assign bus_receive_in = bus_transmit_out & ~pull_low_reg;
endmodule

// ==== cmc_map.svh ====
// Register offsets, fields, reset values and timing constants of the CAN mode control block
// Functional notes
// - Controller speaks CAN 2.0 A and B, standard and extended identifiers, as active node
// - Bus bit rates up to one megabit per second are supported
// - Two transmit mailboxes and one three-stage receive queue are provided
// - Six acceptance filter banks with configurable scale are provided
// - Mailboxes and registers appear as 16-byte pages chosen by a page select
// - Software sets init_request; device sets init_acknowledge once initialising
// - Software clears init_request; device clears init_acknowledge after leaving initialisation
// - In initialisation, traffic stops and bus_transmit_out is held recessive high
// - Entering initialisation leaves all configuration registers unchanged
// - After release, device waits for 11 consecutive recessive bits before bus traffic
// - Setting low_power_request enters sleep with the controller clock stopped
// - In sleep, registers stay accessible but status bits are not updated; here only the sync bit is frozen and init acknowledge is cleared
// - An init_request made during sleep is not acknowledged
// - Sleep ends when software clears low_power_request or bus activity is seen; here bus activity ends sleep only with auto_wakeup_select set
// - With auto_wakeup_select, bus activity in sleep clears low_power_request by hardware
// - With wakeup_irq_enable, bus activity in sleep raises the wake-up interrupt
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH
`define CMC_CTRL_OFS 12'h000
`define CMC_STAT_OFS 12'h004
`define CMC_IEN_OFS 12'h008
`define CMC_PAGE_OFS 12'h00C
`define CMC_BRP_OFS 12'h010
`define CMC_FILT_ACT_OFS 12'h014
`define CMC_WIN_OFS 12'h040
`define CMC_WIN_MASK 12'hFC0
`define CMC_CTRL_INIT_REQ 0
`define CMC_CTRL_LPRQ 1
`define CMC_CTRL_AWU 2
`define CMC_STAT_INIT_ACK 0
`define CMC_STAT_SLAK 1
`define CMC_STAT_WKUI 3
`define CMC_STAT_SYNC 4
`define CMC_IEN_WKU 0
`define CMC_CTRL_RST 8'h01
`define CMC_STAT_RST 8'h01
`define CMC_BRP_RST 16'h0063
`define CMC_CLK_MHZ 100
`define CMC_MAX_KBPS 1000
`define CMC_MIN_BIT_CYC ((`CMC_CLK_MHZ * 1000) / `CMC_MAX_KBPS)
`define CMC_IDLE_BITS 11
`define CMC_PAGES 8
`define CMC_PAGE_BYTES 16
`define CMC_TX_MBOX 2
`define CMC_RX_STAGES 3
`define CMC_FILT_BANKS 6
`endif

// ==== cmc_mode_ctrl.sv ====
// CAN mode control: init handshake, bus-idle sync, sleep and wake-up, paged register window
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "cmc_map.svh"
module cmc_mode_ctrl #(
  parameter int PAGES = `CMC_PAGES,
  parameter int PAGE_BYTES = `CMC_PAGE_BYTES,
  parameter int FILT_BANKS = `CMC_FILT_BANKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_receive_in,
  output logic bus_transmit_out,
  output logic bus_active,
  output logic wakeup_irq
);
  localparam int WIN_WORDS = PAGES * PAGE_BYTES;

  logic [7:0] master_control_reg;
  logic [7:0] master_status_reg;
  logic [7:0] interrupt_enable_reg;
  logic [7:0] page_select_reg;
  logic [15:0] bit_prescale_reg;
  logic [FILT_BANKS-1:0] filter_active_reg;
  logic [7:0] window_reg [WIN_WORDS];
  cmc_pkg::cmc_mode_t mode_reg;
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic rx_prev_reg;
  logic [15:0] bit_cnt_reg;
  logic [3:0] idle_cnt_reg;

  logic init_request;
  logic low_power_request;
  logic auto_wakeup_select;
  logic wakeup_irq_enable;
  logic init_acknowledge;
  logic wr_acc;
  logic bit_tick;
  logic rx_edge;
  logic idle_seen;
  logic hw_wake;
  logic [31:0] rd_word;

  assign init_request = master_control_reg[`CMC_CTRL_INIT_REQ];
  assign low_power_request = master_control_reg[`CMC_CTRL_LPRQ];
  assign auto_wakeup_select = master_control_reg[`CMC_CTRL_AWU];
  assign wakeup_irq_enable = interrupt_enable_reg[`CMC_IEN_WKU];
  assign init_acknowledge = master_status_reg[`CMC_STAT_INIT_ACK];
  assign wr_acc = psel && penable && pwrite;
  // Falling edge on the line marks bus activity during sleep
  assign rx_edge = rx_prev_reg && !rx_sync_reg;
  assign hw_wake = (mode_reg == cmc_pkg::CMC_SLEEP) && rx_edge;
  assign bit_tick = (bit_cnt_reg == 16'h0000);
  assign idle_seen = bit_tick && rx_sync_reg && (idle_cnt_reg == 4'(`CMC_IDLE_BITS - 1));

  function automatic logic in_window(input logic [11:0] a);
    in_window = (a & `CMC_WIN_MASK) == `CMC_WIN_OFS;
  endfunction

  // Two-stage synchroniser on the receive pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= bus_receive_in;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // Bit-rate enable; divider held at its reload value in sleep to mimic the stopped clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_reg <= 16'h0000;
    end else if (mode_reg == cmc_pkg::CMC_SLEEP) begin
      bit_cnt_reg <= bit_prescale_reg;
    end else if (bit_tick) begin
      bit_cnt_reg <= bit_prescale_reg;
    end else begin
      bit_cnt_reg <= bit_cnt_reg - 16'h0001;
    end
  end

  // Recessive bit counter for bus-idle detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_reg <= 4'h0;
    end else if (mode_reg != cmc_pkg::CMC_SYNC) begin
      idle_cnt_reg <= 4'h0;
    end else if (!rx_sync_reg) begin
      idle_cnt_reg <= 4'h0;
    end else if (bit_tick && idle_cnt_reg != 4'(`CMC_IDLE_BITS - 1)) begin
      idle_cnt_reg <= idle_cnt_reg + 4'h1;
    end
  end

  // Operating mode sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= cmc_pkg::CMC_INIT;
    end else begin
      case (mode_reg)
        cmc_pkg::CMC_INIT: begin
          if (low_power_request) begin
            mode_reg <= cmc_pkg::CMC_SLEEP;
          end else if (!init_request) begin
            mode_reg <= cmc_pkg::CMC_SYNC;
          end
        end
        cmc_pkg::CMC_SYNC: begin
          if (init_request) begin
            mode_reg <= cmc_pkg::CMC_INIT;
          end else if (low_power_request) begin
            mode_reg <= cmc_pkg::CMC_SLEEP;
          end else if (idle_seen) begin
            mode_reg <= cmc_pkg::CMC_NORMAL;
          end
        end
        cmc_pkg::CMC_NORMAL: begin
          if (init_request) begin
            mode_reg <= cmc_pkg::CMC_INIT;
          end else if (low_power_request) begin
            mode_reg <= cmc_pkg::CMC_SLEEP;
          end
        end
        default: begin
          if (!low_power_request) begin
            mode_reg <= init_request ? cmc_pkg::CMC_INIT : cmc_pkg::CMC_SYNC;
          end
        end
      endcase
    end
  end

  // Status register; acknowledge bits follow the mode; while asleep the init acknowledge is cleared and the sync bit is frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_status_reg <= `CMC_STAT_RST;
    end else begin
      if (mode_reg != cmc_pkg::CMC_SLEEP) begin
        master_status_reg[`CMC_STAT_INIT_ACK] <= (mode_reg == cmc_pkg::CMC_INIT);
        master_status_reg[`CMC_STAT_SYNC] <= (mode_reg == cmc_pkg::CMC_NORMAL);
      end else begin
        master_status_reg[`CMC_STAT_INIT_ACK] <= 1'b0;
      end
      master_status_reg[`CMC_STAT_SLAK] <= (mode_reg == cmc_pkg::CMC_SLEEP);
      // Set wins over a write-one clear
      if (hw_wake) begin
        master_status_reg[`CMC_STAT_WKUI] <= 1'b1;
      end else if (wr_acc && paddr == `CMC_STAT_OFS && pwdata[`CMC_STAT_WKUI]) begin
        master_status_reg[`CMC_STAT_WKUI] <= 1'b0;
      end
    end
  end

  // Control register; hardware clears sleep request on automatic wake-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_control_reg <= `CMC_CTRL_RST;
    end else if (hw_wake && auto_wakeup_select) begin
      master_control_reg[`CMC_CTRL_LPRQ] <= 1'b0;
    end else if (wr_acc && paddr == `CMC_CTRL_OFS) begin
      master_control_reg <= {5'h00, pwdata[2:0]};
    end
  end

  // Configuration registers; untouched by mode changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable_reg <= 8'h00;
      page_select_reg <= 8'h00;
      bit_prescale_reg <= `CMC_BRP_RST;
      filter_active_reg <= '0;
    end else if (wr_acc) begin
      if (paddr == `CMC_IEN_OFS) begin
        interrupt_enable_reg <= {7'h00, pwdata[0]};
      end else if (paddr == `CMC_PAGE_OFS) begin
        page_select_reg <= 8'(pwdata[$clog2(PAGES)-1:0]);
      end else if (paddr == `CMC_BRP_OFS && init_acknowledge) begin
        bit_prescale_reg <= pwdata[15:0];
      end else if (paddr == `CMC_FILT_ACT_OFS) begin
        filter_active_reg <= pwdata[FILT_BANKS-1:0];
      end
    end
  end

  // Paged window storage, one byte per word, selected by page select
  genvar gi;
  generate
    for (gi = 0; gi < WIN_WORDS; gi++) begin : g_win
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          window_reg[gi] <= 8'h00;
        end else if (wr_acc && in_window(paddr)
                     && (page_select_reg * PAGE_BYTES + int'(paddr[5:2])) == gi) begin
          window_reg[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // Read mux
  always_comb begin
    rd_word = 32'h00000000;
    if (paddr == `CMC_CTRL_OFS) begin
      rd_word = {24'h000000, master_control_reg};
    end else if (paddr == `CMC_STAT_OFS) begin
      rd_word = {24'h000000, master_status_reg};
    end else if (paddr == `CMC_IEN_OFS) begin
      rd_word = {24'h000000, interrupt_enable_reg};
    end else if (paddr == `CMC_PAGE_OFS) begin
      rd_word = {24'h000000, page_select_reg};
    end else if (paddr == `CMC_BRP_OFS) begin
      rd_word = {16'h0000, bit_prescale_reg};
    end else if (paddr == `CMC_FILT_ACT_OFS) begin
      rd_word = 32'(filter_active_reg);
    end else if (in_window(paddr)) begin
      rd_word = {24'h000000, window_reg[page_select_reg[2:0] * PAGE_BYTES + paddr[5:2]]};
    end
  end

  // APB answer: zero wait states, registered read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_word;
      end
    end
  end

  // Pin and interrupt outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_transmit_out <= 1'b1;
      bus_active <= 1'b0;
      wakeup_irq <= 1'b0;
    end else begin
      bus_transmit_out <= 1'b1;
      bus_active <= (mode_reg == cmc_pkg::CMC_NORMAL);
      wakeup_irq <= master_status_reg[`CMC_STAT_WKUI] && wakeup_irq_enable;
    end
  end

  // Assertions
  init_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == cmc_pkg::CMC_INIT) |=> init_acknowledge)
    else $error("init ack missing");
  leave_init_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == cmc_pkg::CMC_SYNC) |=> !init_acknowledge)
    else $error("init ack not cleared");
  tx_recessive_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == cmc_pkg::CMC_INIT) |-> bus_transmit_out)
    else $error("tx not recessive");
  sleep_no_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == cmc_pkg::CMC_SLEEP) ##1 (mode_reg == cmc_pkg::CMC_SLEEP) |-> !init_acknowledge)
    else $error("ack during sleep");
  idle_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(mode_reg == cmc_pkg::CMC_NORMAL) |-> $past(idle_cnt_reg) == 4'(`CMC_IDLE_BITS - 1))
    else $error("normal without idle");
  idle_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == cmc_pkg::CMC_SYNC) && !rx_sync_reg |=> idle_cnt_reg == 4'h0)
    else $error("idle count not restarted");
  auto_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    hw_wake && auto_wakeup_select |=> !low_power_request ##1 mode_reg != cmc_pkg::CMC_SLEEP)
    else $error("auto wake failed");
  wake_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    hw_wake && wakeup_irq_enable ##1 wakeup_irq_enable |=> wakeup_irq)
    else $error("wake irq missing");
  sw_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == cmc_pkg::CMC_SLEEP) && !low_power_request |=> mode_reg != cmc_pkg::CMC_SLEEP)
    else $error("sleep not left");
  config_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == cmc_pkg::CMC_NORMAL) && init_request |=> $stable(bit_prescale_reg))
    else $error("config changed on init entry");
  sleep_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == cmc_pkg::CMC_SLEEP) |=> $stable(master_status_reg[`CMC_STAT_SYNC]))
    else $error("status changed in sleep");
  sleep_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == cmc_pkg::CMC_SLEEP) |=> master_status_reg[`CMC_STAT_SLAK])
    else $error("sleep ack missing");
  wake_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    hw_wake |=> master_status_reg[`CMC_STAT_WKUI])
    else $error("wake flag not set");
  init_cov: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(init_acknowledge));
  normal_cov: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(bus_active));
  wake_cov: cover property (@(posedge pclk) disable iff (!presetn)
    hw_wake && auto_wakeup_select);
endmodule

// ==== cmc_pkg.sv ====
// Types of the CAN mode control block
package cmc_pkg;
  typedef enum logic [1:0] {
    CMC_INIT,
    CMC_SYNC,
    CMC_NORMAL,
    CMC_SLEEP
  } cmc_mode_t;
endpackage

// ==== test_can_controller_mode_control.sv ====
// Register-level bench of the CAN mode control block
`timescale 1ns/1ps
`include "cmc_map.svh"
module test_can_controller_mode_control;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bus_receive_in;
  logic bus_transmit_out;
  logic bus_active;
  logic wakeup_irq;
  logic node_dominant = 1'b0;
  logic [31:0] q;
  int miscompares = 0;
  int checks = 0;
  int n;

  always #5 pclk = ~pclk;

  cmc_mode_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_receive_in(bus_receive_in), .bus_transmit_out(bus_transmit_out),
    .bus_active(bus_active), .wakeup_irq(wakeup_irq));

  cmc_bus_node bus (.pclk(pclk), .bus_transmit_out(bus_transmit_out),
    .node_dominant(node_dominant), .bus_receive_in(bus_receive_in));

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk({31'h0, pready}, 32'h1, "ready timeout");
    q = prdata;
    chk({31'h0, pslverr}, 32'h0, "slave error");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(q, exp, what);
  endtask

  // Read until the masked field matches, bounded
  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp,
                      input string what);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h0);
      k++;
    end while ((q & m) !== exp && k < 30);
    chk(q & m, exp, what);
  endtask

  task automatic pulse_dominant(input int cyc);
    node_dominant <= 1'b1;
    repeat (cyc) @(posedge pclk);
    node_dominant <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    #100us;
    $display("ERROR at %0t: watchdog expired", $time);
    miscompares++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`CMC_CTRL_OFS, 32'h1, "control reset");
    rd(`CMC_STAT_OFS, 32'h1, "init ack at reset");
    chk({31'h0, bus_transmit_out}, 32'h1, "tx recessive in init");
    apb(1'b1, `CMC_BRP_OFS, 32'h3);
    apb(1'b1, `CMC_FILT_ACT_OFS, 32'h15);
    // Paged window entries on pages two and six, written while initialising
    apb(1'b1, `CMC_PAGE_OFS, 32'h2);
    apb(1'b1, `CMC_WIN_OFS + 12'h004, 32'h5A);
    apb(1'b1, `CMC_PAGE_OFS, 32'h6);
    apb(1'b1, `CMC_WIN_OFS + 12'h004, 32'hC3);
    rd(`CMC_WIN_OFS + 12'h004, 32'hC3, "page six entry");
    apb(1'b1, `CMC_PAGE_OFS, 32'h2);
    rd(`CMC_WIN_OFS + 12'h004, 32'h5A, "page two entry");
    rd(`CMC_PAGE_OFS, 32'h2, "page select");
    apb(1'b1, 12'h020, 32'hA5); // unmapped
    rd(12'h020, 32'h0, "unmapped read");
    // Leave init while the bus is busy, then release it
    node_dominant <= 1'b1;
    apb(1'b1, `CMC_CTRL_OFS, 32'h0);
    poll(`CMC_STAT_OFS, 32'h1, 32'h0, "init ack cleared");
    repeat (40) @(posedge pclk);
    chk({31'h0, bus_active}, 32'h0, "no traffic on busy bus");
    node_dominant <= 1'b0;
    n = 0;
    while (bus_active !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= 40 && n <= 70, 1, "idle sync length");
    apb(1'b1, `CMC_BRP_OFS, 32'h7);
    rd(`CMC_BRP_OFS, 32'h3, "timing locked outside init");
    apb(1'b1, `CMC_CTRL_OFS, 32'h1);
    poll(`CMC_STAT_OFS, 32'h1, 32'h1, "init ack set");
    chk({31'h0, bus_active}, 32'h0, "traffic stopped in init");
    rd(`CMC_BRP_OFS, 32'h3, "timing kept");
    rd(`CMC_FILT_ACT_OFS, 32'h15, "filters kept");
    // Sleep, manual wake-up
    apb(1'b1, `CMC_IEN_OFS, 32'h1);
    apb(1'b1, `CMC_CTRL_OFS, 32'h2);
    poll(`CMC_STAT_OFS, 32'h3, 32'h2, "sleep ack");
    apb(1'b1, `CMC_FILT_ACT_OFS, 32'h2A);
    rd(`CMC_FILT_ACT_OFS, 32'h2A, "access in sleep");
    apb(1'b1, `CMC_CTRL_OFS, 32'h3);
    repeat (20) @(posedge pclk);
    rd(`CMC_STAT_OFS, 32'h2, "init not acked in sleep");
    apb(1'b1, `CMC_CTRL_OFS, 32'h2);
    pulse_dominant(8);
    repeat (4) @(posedge pclk);
    chk({31'h0, wakeup_irq}, 32'h1, "wake irq");
    rd(`CMC_CTRL_OFS, 32'h2, "no auto clear");
    apb(1'b1, `CMC_CTRL_OFS, 32'h0);
    poll(`CMC_STAT_OFS, 32'h2, 32'h0, "software wake");
    apb(1'b1, `CMC_STAT_OFS, 32'h8);
    repeat (2) @(posedge pclk);
    chk({31'h0, wakeup_irq}, 32'h0, "wake flag cleared");
    // Sleep, automatic wake-up
    apb(1'b1, `CMC_CTRL_OFS, 32'h6);
    poll(`CMC_STAT_OFS, 32'h2, 32'h2, "sleep ack auto");
    pulse_dominant(8);
    poll(`CMC_CTRL_OFS, 32'h2, 32'h0, "auto wake clears request");
    chk({31'h0, wakeup_irq}, 32'h1, "irq with auto wake");
    apb(1'b1, `CMC_IEN_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, wakeup_irq}, 32'h0, "irq masked");
    rd(`CMC_STAT_OFS, 32'h8, "wake flag held");
    close_out();
  end
endmodule
